// ### rtl/acl_pkg.sv
package acl_pkg;

  localparam int CLK_MHZ = 25;

  localparam logic [7:0] CMD_WRITE = 8'h0A;
  localparam logic [7:0] CMD_READ = 8'h0B;
  localparam logic [7:0] CMD_FIFO = 8'h0D;

  localparam int ADDR_W = 7;
  localparam int REG_DEPTH = 128;
  localparam logic [6:0] ADDR_STATUS = 7'h0B;
  localparam logic [6:0] ADDR_STATUS2 = 7'h44;
  localparam logic [6:0] PROT_LAST = 7'h43;
  localparam logic [6:0] USER_LAST = 7'h45;
  localparam logic [6:0] DRDY_A_FIRST = 7'h08;
  localparam logic [6:0] DRDY_A_LAST = 7'h0A;
  localparam logic [6:0] DRDY_B_FIRST = 7'h0E;
  localparam logic [6:0] DRDY_B_LAST = 7'h17;
  localparam int ERR_BIT = 7;
  localparam logic ERR_RESET = 1'b1;
  localparam logic [7:0] FIFO_EMPTY_BYTE = 8'h00;

  localparam int DRDY_CLR_MAX_US = 120;
  localparam int DRDY_CLR_MAX_CYC = DRDY_CLR_MAX_US * CLK_MHZ;

  localparam int CHK_W_DEF = 99;
  localparam int CHK_IDX_W = 10;

  typedef enum logic [2:0] {
    PH_CMD,
    PH_ADDR,
    PH_WDATA,
    PH_RDATA,
    PH_FIFO,
    PH_IGNORE
  } acl_phase_e;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } acl_wr_s;

endpackage : acl_pkg

// ### rtl/acl_reg_mem.sv
`timescale 1ns/1ns
module acl_reg_mem
  import acl_pkg::*;
#(
  parameter int DEPTH = REG_DEPTH,
  parameter int AW = ADDR_W,
  parameter int DW = 8
)(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr_a,
  output logic [DW-1:0] rd_data_a,
  input wire logic [AW-1:0] rd_addr_b,
  output logic [DW-1:0] rd_data_b
);

  logic [DW-1:0] mem [DEPTH];

  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("acl_reg_mem: DEPTH must equal 2**AW");
  end

  // Reset to zero so the first check pass sees known contents
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
      rd_data_a <= '0;
      rd_data_b <= '0;
    end
    else
    begin
      if (wr_en)
        mem[wr_addr] <= wr_data;
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end

endmodule : acl_reg_mem

// ### rtl/acl_spi_port.sv
`timescale 1ns/1ns
// Operation
// R1: Mode 0, sample rising, shift falling
// R2: First byte command: write, read, FIFO
// R3: Register commands: address byte, then data
// R4: FIFO read: data follows command directly
// R5: FIFO sample sent high byte first
// R6: Host reads whole sample sets per burst
// R7: Bursts of any length, all commands
// R8: Register address increments per data byte
// R9: User registers valid up to 0x45
// R10: Seven-bit address, wraps over 128 locations
// R11: Data output released except read data
// R12: Host ignores output during writes
// R13: FIFO pops on serial clock
// R14: Registers 0x00-0x43 check-code protected
// R15: Check bits recomputed on protected write
// R16: Check mismatch sets register-error flag
// R17: Error flag set at reset, cleared first write
// R18: Invalid command ignored, output stays released
// R19: Data register read clears data-ready
// R20: Chip select high ends transaction
module acl_spi_port
  import acl_pkg::*;
#(
  parameter int CHK_W = CHK_W_DEF
)(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic [15:0] fifo_data,
  input wire logic fifo_valid,
  output logic fifo_pop,
  output logic drdy_clear,
  output acl_wr_s reg_wr,
  output logic reg_wr_stb,
  output logic err_user_regs
);

  if (CHK_W < CHK_IDX_W + 1) begin : g_bad_chk
    $error("acl_spi_port: CHK_W too small for SEC-DED columns");
  end
  // Hamming column per bit: index+1 plus overall parity
  function automatic logic [CHK_W-1:0] chk_col(input logic [6:0] a, input logic [7:0] d);
    logic [CHK_W-1:0] acc;
    logic [CHK_IDX_W-1:0] idx;
    acc = '0;
    idx = '0;
    for (int b = 0; b < 8; b++)
    begin
      idx = {a, 3'(b)} + 10'h001;
      if (d[b])
      begin
        acc[CHK_IDX_W-1:0] = acc[CHK_IDX_W-1:0] ^ idx;
        acc[CHK_IDX_W] = ~acc[CHK_IDX_W];
      end
    end
    return acc;
  endfunction : chk_col
  function automatic logic in_range(input logic [6:0] a, input logic [6:0] lo,
                                    input logic [6:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  acl_phase_e phase;
  acl_phase_e next_phase;
  logic sclk_q;
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [6:0] addr;
  logic cmd_rd;
  logic load_pend;
  logic [7:0] tx;
  logic msb_sel;
  logic first_wr_done;
  logic [6:0] scrub_addr;
  logic [6:0] scrub_aq;
  logic scrub_vld;
  logic [CHK_W-1:0] chk_acc;
  logic [CHK_W-1:0] chk_stored;
  logic dirty;
  logic [7:0] q_a;
  logic [7:0] q_b;
  // Inputs are synchronous to ref_clk; edges found against last sample
  wire sclk_rise = sclk & ~sclk_q & ~cs_n; // [R1]
  wire sclk_fall = ~sclk & sclk_q & ~cs_n; // [R1]
  wire byte_done = sclk_rise && (bit_cnt == 3'd7);
  wire [7:0] rx_byte = {shift_in, mosi};
  wire wr_en = byte_done && (phase == PH_WDATA);
  wire prot_wr = wr_en && (addr <= PROT_LAST);
  wire do_load = sclk_fall && load_pend;
  wire do_shift = sclk_fall && !load_pend && !miso_oe_n;
  wire stat_addr = (addr == ADDR_STATUS) || (addr == ADDR_STATUS2);
  wire [7:0] reg_byte = stat_addr ? {err_user_regs, q_a[ERR_BIT-1:0]} : q_a; // [R16]
  wire [7:0] fifo_byte = !fifo_valid ? FIFO_EMPTY_BYTE :
                         (msb_sel ? fifo_data[15:8] : fifo_data[7:0]); // [R5]
  wire [7:0] load_byte = (phase == PH_FIFO) ? fifo_byte : reg_byte; // [R9]
  wire drdy_hit = in_range(addr, DRDY_A_FIRST, DRDY_A_LAST) ||
                  in_range(addr, DRDY_B_FIRST, DRDY_B_LAST);
  wire pass_end = scrub_vld && (scrub_aq == PROT_LAST);
  wire [CHK_W-1:0] chk_result = chk_acc ^ chk_col(scrub_aq, q_b);
  wire mismatch = pass_end && !dirty && !prot_wr && (chk_result != chk_stored); // [R16]

  always_comb
  begin
    next_phase = phase;
    if (byte_done)
    begin
      case (phase)
        PH_CMD:
          if (rx_byte == CMD_WRITE || rx_byte == CMD_READ)
            next_phase = PH_ADDR; // [R2] [R3]
          else if (rx_byte == CMD_FIFO)
            next_phase = PH_FIFO; // [R2] [R4]
          else
            next_phase = PH_IGNORE; // [R18]
        PH_ADDR:
          next_phase = cmd_rd ? PH_RDATA : PH_WDATA; // [R3]
        default:
          next_phase = phase; // [R7]
      endcase
    end
  end
  acl_reg_mem #(
    .DEPTH(REG_DEPTH),
    .AW(ADDR_W),
    .DW(8)
  ) u_mem (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr_en(wr_en),
    .wr_addr(addr),
    .wr_data(rx_byte),
    .rd_addr_a(addr),
    .rd_data_a(q_a),
    .rd_addr_b(scrub_addr),
    .rd_data_b(q_b)
  );
  // Serial front end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_q <= 1'b0;
      phase <= PH_CMD;
      bit_cnt <= '0;
      shift_in <= '0;
      cmd_rd <= 1'b0;
      load_pend <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk;
      if (cs_n)
      begin
        phase <= PH_CMD; // [R20]
        bit_cnt <= '0;
        load_pend <= 1'b0;
      end
      else
      begin
        phase <= next_phase;
        if (sclk_rise)
        begin
          bit_cnt <= bit_cnt + 3'd1;
          shift_in <= rx_byte[6:0];
        end
        if (byte_done && phase == PH_CMD)
          cmd_rd <= (rx_byte == CMD_READ);
        if (byte_done && (next_phase == PH_RDATA || next_phase == PH_FIFO))
          load_pend <= 1'b1;
        else if (do_load)
          load_pend <= 1'b0;
      end
    end
  end

  // Address, output shifter and FIFO byte select
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addr <= '0;
      tx <= '0;
      miso_out <= 1'b0;
      miso_oe_n <= 1'b1;
      msb_sel <= 1'b1;
      fifo_pop <= 1'b0;
      drdy_clear <= 1'b0;
    end
    else
    begin
      fifo_pop <= 1'b0;
      drdy_clear <= 1'b0;
      if (cs_n)
      begin
        miso_oe_n <= 1'b1; // [R11] [R20]
        msb_sel <= 1'b1;
      end
      else
      begin
        if (byte_done && phase == PH_ADDR)
          addr <= rx_byte[6:0]; // [R3] [R10]
        else if (wr_en || (do_load && phase == PH_RDATA))
          addr <= addr + 7'd1; // [R8] [R10]
        if (do_load)
        begin
          tx <= load_byte;
          miso_out <= load_byte[7];
          miso_oe_n <= 1'b0; // [R11]
          if (phase == PH_FIFO)
          begin
            msb_sel <= ~msb_sel;
            fifo_pop <= !msb_sel && fifo_valid; // [R5] [R13]
          end
          else
            drdy_clear <= drdy_hit; // [R19]
        end
        else if (do_shift)
        begin
          tx <= {tx[6:0], 1'b0};
          miso_out <= tx[6]; // [R1]
        end
      end
    end
  end

  // Write strobe seen by the rest of the device
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_wr <= '0;
      reg_wr_stb <= 1'b0;
    end
    else
    begin
      reg_wr_stb <= wr_en;
      if (wr_en)
        reg_wr <= '{addr: addr, data: rx_byte};
    end
  end
  // Background check pass; a protected write restarts it and re-stores
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scrub_addr <= '0;
      scrub_aq <= '0;
      scrub_vld <= 1'b0;
      chk_acc <= '0;
      chk_stored <= '0;
      dirty <= 1'b1;
    end
    else if (prot_wr)
    begin
      scrub_addr <= '0; // [R15]
      scrub_vld <= 1'b0;
      chk_acc <= '0;
      dirty <= 1'b1;
    end
    else
    begin
      scrub_addr <= (scrub_addr == PROT_LAST) ? 7'd0 : scrub_addr + 7'd1; // [R14]
      scrub_aq <= scrub_addr;
      scrub_vld <= 1'b1;
      if (scrub_vld)
        chk_acc <= pass_end ? '0 : chk_result;
      if (pass_end && dirty)
      begin
        chk_stored <= chk_result; // [R15]
        dirty <= 1'b0;
      end
    end
  end
  // Set wins over the first-write clear
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      err_user_regs <= ERR_RESET; // [R17]
      first_wr_done <= 1'b0;
    end
    else
    begin
      if (wr_en)
        first_wr_done <= 1'b1;
      if (mismatch)
        err_user_regs <= 1'b1; // [R16]
      else if (wr_en && !first_wr_done)
        err_user_regs <= 1'b0; // [R17]
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  cmd_ignore_a: assert property (phase == PH_IGNORE |-> miso_oe_n) // [R18]
    else $error("output driven after invalid command");
  cs_release_a: assert property (cs_n |=> phase == PH_CMD && bit_cnt == 3'd0 && miso_oe_n) // [R20]
    else $error("chip select high did not end transaction");
  oe_read_only_a: assert property (!miso_oe_n |-> phase == PH_RDATA || phase == PH_FIFO) // [R11]
    else $error("output driven outside read data");
  fifo_direct_a: assert property (byte_done && phase == PH_CMD && rx_byte == CMD_FIFO && !cs_n
                                  |=> phase == PH_FIFO && load_pend) // [R4]
    else $error("FIFO command not followed by data phase");
  fifo_lsb_pop_a: assert property (fifo_pop |-> msb_sel && $past(!msb_sel)) // [R5]
    else $error("FIFO popped before low byte");
  addr_load_a: assert property (byte_done && phase == PH_ADDR && !cs_n
                                |=> addr == $past(rx_byte[6:0])) // [R3]
    else $error("address byte not taken");
  rd_incr_a: assert property (do_load && phase == PH_RDATA && !cs_n
                              |=> addr == $past(addr) + 7'd1) // [R8]
    else $error("read burst address did not advance");
  wr_incr_a: assert property (wr_en && !cs_n
                              |=> reg_wr_stb && reg_wr.addr == $past(addr)
                                  && addr == $past(addr) + 7'd1) // [R8]
    else $error("write burst address did not advance");
  err_set_a: assert property (mismatch |=> err_user_regs ##1 err_user_regs) // [R16]
    else $error("check mismatch did not set error flag");
  err_clear_a: assert property (wr_en && !first_wr_done && !mismatch |=> !err_user_regs) // [R17]
    else $error("first write did not clear error flag");
  chk_store_a: assert property (pass_end && dirty && !prot_wr |=> chk_stored == $past(chk_result)
                                && !dirty) // [R15]
    else $error("check bits not restored after write");
  drdy_src_a: assert property (drdy_clear |-> $past(phase) == PH_RDATA && $past(drdy_hit)) // [R19]
    else $error("data-ready clear without data register read");
  wr_burst_c: cover property (wr_en ##[1:100] wr_en);
  rd_status_c: cover property (do_load && phase == PH_RDATA && stat_addr);
  fifo_pair_c: cover property (fifo_pop ##[1:100] fifo_pop);
  err_hit_c: cover property (mismatch);
  user_top_c: cover property (do_load && phase == PH_RDATA && addr == USER_LAST); // [R9]

endmodule : acl_spi_port

// ### verification/acl_spi_host.sv
`timescale 1ns/1ns
module acl_spi_host (
  input wire logic ref_clk,
  input wire logic miso,
  output logic cs_n,
  output logic sclk,
  output logic mosi
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_clk

  task automatic cs_low();
    wait_clk(1);
    cs_n = 1'b0;
    wait_clk(3);
  endtask : cs_low

  // Clock parks low after the frame closes, no spare byte load
  task automatic cs_high();
    cs_n = 1'b1;
    wait_clk(1);
    sclk = 1'b0;
    mosi = ~mosi;
    wait_clk(3);
  endtask : cs_high

  // Data moves on the fall, both sides take it on the rise
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx, input int nbits);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      sclk = 1'b0;
      mosi = tx[i];
      wait_clk(4);
      sclk = 1'b1;
      rx[i] = miso;
      wait_clk(4);
    end
  endtask : xbyte
endmodule : acl_spi_host

// ### verification/spi_register_port_seu_check_tb_top.sv
`timescale 1ns/1ns
module spi_register_port_seu_check_tb_top;
  import acl_pkg::*;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic drdy;
  } acl_row_s;

  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cs_n, sclk, mosi, miso, fifo_valid, miso_out, miso_oe_n;
  logic fifo_pop, drdy_clear, reg_wr_stb, err_user_regs;
  logic keep = 1'b0;
  logic [7:0] rx;
  logic [15:0] fifo_data;
  acl_wr_s reg_wr;
  int n_stb = 0;
  int n_pop = 0;
  int n_drdy = 0;
  int oe_seen = 0;
  int failures = 0;
  int num_checks = 0;
  logic [15:0] smp [4] = '{16'h1234, 16'hABCD, 16'h5566, 16'h7788};
  logic [7:0] fexp [9] = '{8'h12, 8'h34, 8'hAB, 8'hCD, 8'h55, 8'h66, 8'h77, 8'h88, 8'h00};
  logic [7:0] bad [5] = '{8'h00, 8'h0C, 8'h0E, 8'h8A, 8'hFF};
  // Status rows read bit 7 as the error flag, already clear
  acl_row_s rows [12] = '{
    '{7'h10, 8'hA5, 8'hA5, 1'b1}, '{7'h00, 8'h3C, 8'h3C, 1'b0},
    '{7'h08, 8'h81, 8'h81, 1'b1}, '{7'h0A, 8'h42, 8'h42, 1'b1},
    '{7'h0E, 8'h24, 8'h24, 1'b1}, '{7'h17, 8'h7E, 8'h7E, 1'b1},
    '{7'h18, 8'h11, 8'h11, 1'b0}, '{7'h06, 8'h22, 8'h22, 1'b0},
    '{7'h0B, 8'h95, 8'h15, 1'b0}, '{7'h44, 8'hC6, 8'h46, 1'b0},
    '{7'h45, 8'h5A, 8'h5A, 1'b0}, '{7'h7F, 8'hC3, 8'hC3, 1'b0}};

  always #20 ref_clk = ~ref_clk;
  assign fifo_valid = (n_pop < 4);
  assign fifo_data = smp[n_pop[1:0]];
  // Keeper holds the last driven level while released
  assign miso = (miso_oe_n === 1'b0) ? miso_out : keep;

  always @(posedge ref_clk)
  begin
    if (miso_oe_n === 1'b0)
      keep <= miso_out;
    n_stb <= n_stb + int'(reg_wr_stb === 1'b1);
    n_pop <= n_pop + int'(fifo_pop === 1'b1);
    n_drdy <= n_drdy + int'(drdy_clear === 1'b1);
    oe_seen <= oe_seen | int'(miso_oe_n === 1'b0);
  end

  acl_spi_port u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid), .fifo_pop(fifo_pop), .drdy_clear(drdy_clear), .reg_wr(reg_wr),
    .reg_wr_stb(reg_wr_stb), .err_user_regs(err_user_regs));
  acl_spi_host u_host (.ref_clk(ref_clk), .miso(miso), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));

  task automatic test_done();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_val({8'h00, got}, {8'h00, exp});
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit

  task automatic xb(input logic [7:0] d);
    u_host.xbyte(d, rx, 8);
  endtask : xb

  task automatic open_x(input logic [7:0] cmd, input logic [7:0] a);
    u_host.cs_low();
    xb(cmd);
    if (cmd != CMD_FIFO)
      xb(a);
  endtask : open_x

  // Odd stop leaves the sample unpopped; whole sets otherwise
  task automatic fifo_burst(input int first, input int last);
    open_x(CMD_FIFO, 8'h00);
    for (int i = first; i <= last; i++)
    begin
      xb(8'h00);
      chk_byte(rx, fexp[i]);
    end
    u_host.cs_high();
  endtask : fifo_burst

  task automatic wait_err();
    int i;
    for (i = 0; i < 400; i++)
    begin
      if (err_user_regs === 1'b0)
        break;
      u_host.wait_clk(1);
    end
    if (i == 400)
    begin
      failures++;
      test_done();
    end
  endtask : wait_err

  initial
  begin
    int s;
    int d;
    repeat (20) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    u_host.wait_clk(1);
    chk_bit(err_user_regs, ERR_RESET);
    chk_bit(miso_oe_n, 1'b1);
    chk_bit(fifo_pop, 1'b0);
    chk_val(16'(reg_wr), 16'h0000);
    open_x(CMD_READ, 8'h44);
    xb(8'h00);
    u_host.cs_high();
    chk_byte(rx, 8'h80);
    chk_bit(err_user_regs, 1'b1);
    open_x(CMD_WRITE, 8'h20);
    xb(8'h99);
    u_host.cs_high();
    wait_err();
    chk_bit(err_user_regs, 1'b0);
    foreach (rows[i])
    begin
      s = n_stb;
      d = n_drdy;
      oe_seen = 0;
      open_x(CMD_WRITE, {1'b0, rows[i].addr});
      xb(rows[i].wdata);  // Output ignored while writing
      u_host.cs_high();
      chk_val(16'(oe_seen), 16'h0000);
      chk_val(16'(n_stb - s), 16'h0001);
      chk_val(16'(reg_wr), 16'({rows[i].addr, rows[i].wdata}));
      open_x(CMD_READ, {1'b0, rows[i].addr});
      xb(8'h00);
      u_host.cs_high();
      chk_byte(rx, rows[i].rexp);
      chk_val(16'(n_drdy - d), 16'(rows[i].drdy));
    end
    u_host.wait_clk(200);
    chk_bit(err_user_regs, 1'b0);
    s = n_stb;
    open_x(CMD_WRITE, 8'h7E);
    xb(8'hD0);
    xb(8'hD1);
    xb(8'hD2);
    u_host.cs_high();
    chk_val(16'(n_stb - s), 16'h0003);
    chk_val(16'(reg_wr), 16'({7'h00, 8'hD2}));
    open_x(CMD_READ, 8'h7E);
    for (int i = 0; i < 3; i++)
    begin
      xb(8'h00);
      chk_byte(rx, 8'hD0 + 8'(i));
    end
    u_host.cs_high();
    fifo_burst(0, 2);
    chk_val(16'(n_pop), 16'h0001);
    fifo_burst(2, 8);
    chk_val(16'(n_pop), 16'h0004);
    foreach (bad[i])
    begin
      s = n_stb;
      oe_seen = 0;
      open_x(bad[i], 8'h30);
      xb(8'h55);
      u_host.cs_high();
      chk_val(16'(oe_seen), 16'h0000);
      chk_val(16'(n_stb - s), 16'h0000);
    end
    s = n_stb;
    open_x(CMD_WRITE, 8'h30);
    u_host.xbyte(8'hF0, rx, 4);
    u_host.cs_high();
    chk_val(16'(n_stb - s), 16'h0000);
    open_x(CMD_WRITE, 8'h30);
    xb(8'h6B);
    u_host.cs_high();
    open_x(CMD_READ, 8'h30);
    xb(8'h00);
    u_host.cs_high();
    chk_byte(rx, 8'h6B);
    // Second reset mid-run: flag returns and register contents clear
    arst_n = 1'b0;
    u_host.wait_clk(3);
    arst_n = 1'b1;
    u_host.wait_clk(1);
    chk_bit(err_user_regs, ERR_RESET);
    chk_bit(miso_oe_n, 1'b1);
    chk_val(16'(reg_wr), 16'h0000);
    open_x(CMD_READ, 8'h0B);
    xb(8'h00);
    u_host.cs_high();
    chk_byte(rx, 8'h80);
    test_done();
  end
endmodule : spi_register_port_seu_check_tb_top
